// ==== grmc_consts.svh ====
// Constants of the relaxation and miscellaneous configuration block.
// Assumes a 100 MHz clk_in and register indices at four bytes each.
`ifndef GRMC_CONSTS_SVH
`define GRMC_CONSTS_SVH
// ==========================================
// Register indices, byte address = index * 4
`define GRMC_IDX_RELAX   8'h2a
`define GRMC_IDX_MISC    8'h2b
`define GRMC_IDX_STATUS  8'h40
`define GRMC_IDX_MASK    8'h41
`define GRMC_IDX_LEARN   8'h42
`define GRMC_IDX_CELLV   8'h43
// ==========================================
// Reset values
`define GRMC_RELAX_RST   16'h1039
`define GRMC_MISC_RST    16'h3860
// ==========================================
// Field positions
`define GRMC_LOAD_MASK   16'h0fe0
`define GRMC_DV_MSB      8
`define GRMC_DV_LSB      4
`define GRMC_DT_MSB      3
`define GRMC_DT_LSB      0
`define GRMC_RATE_MSB    15
`define GRMC_RATE_LSB    12
`define GRMC_INS_BIT     11
`define GRMC_REINIT_BIT  10
`define GRMC_MIX_MSB     9
`define GRMC_MIX_LSB     5
`define GRMC_AUTOCLR_BIT 4
`define GRMC_PULLUP_BIT  3
`define GRMC_VEX_BIT     2
`define GRMC_ALERT_MSB   1
`define GRMC_ALERT_LSB   0
// ==========================================
// Timing and scaling
`define GRMC_CLK_NS      10
`define GRMC_TICK_US     175800
`define GRMC_DV_STEP_UV  1250
`define GRMC_VLSB_NV     78125
`define GRMC_RATE_STEP   8
`define GRMC_MIX_STEP_NV 6250
`endif

// ==== grmc_pkg.sv ====
// Types shared by the configuration block and its relaxation detector.
// Assumes nothing of its surroundings.
package grmc_pkg;
   typedef enum logic [1:0] {
      GRMC_SRC_REPORTED  = 2'h0,
      GRMC_SRC_AVAILABLE = 2'h1,
      GRMC_SRC_MIXED     = 2'h2,
      GRMC_SRC_VOLTAGE   = 2'h3
   } grmc_alert_src_type;
   typedef enum logic [3:0] {
      GRMC_LOADED  = 4'h1,
      GRMC_SEARCH  = 4'h2,
      GRMC_QUIET   = 4'h4,
      GRMC_RELAXED = 4'h8
   } grmc_relax_state_type;
endpackage

// ==== grmc_relax_if.sv ====
// Signals between the register side and the relaxation detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface grmc_relax_if;
   logic [15:0] relax_cfg;
   logic [15:0] average_current;
   logic [15:0] cell_voltage;
   logic        unloaded;
   logic        latch_load;
   logic        searching;
   logic        relaxed;
   logic        relax_event;
   modport cfg (output relax_cfg, output average_current, output cell_voltage,
                input unloaded, input latch_load, input searching, input relaxed, input relax_event);
   modport det (input relax_cfg, input average_current, input cell_voltage,
                output unloaded, output latch_load, output searching, output relaxed, output relax_event);
endinterface

// ==== grmc_relax_detect.sv ====
// Relaxation detector: unload test, interval timer, quiet-voltage tracking.
// Assumes measurements arrive on clk_in, already averaged by the gauge core.
`timescale 1ns/1ps
`include "grmc_consts.svh"
module grmc_relax_detect #(
   parameter int unsigned TICK_CYCLES = 17580000,
   parameter int unsigned DV_STEP     = 16
) (
   input wire logic  clk_in,
   input wire logic  rst_b_in,
   grmc_relax_if.det rif
);
   function automatic logic [15:0] grmc_abs_diff(input logic [15:0] a, input logic [15:0] b);
      grmc_abs_diff = (a >= b) ? a - b : b - a;
   endfunction

   logic [31:0]                    base_cnt;
   logic [15:0]                    ivl_cnt;
   logic                           ivl_tick;
   logic [15:0]                    cur_mag;
   logic [15:0]                    load_thr;
   logic [15:0]                    dv_thr;
   logic [15:0]                    prev_v;
   logic                           primed;
   logic                           quiet;
   logic                           unl_now;
   grmc_pkg::grmc_relax_state_type state;
   grmc_pkg::grmc_relax_state_type next_state;

   // ==========================================
   // Thresholds
   assign cur_mag  = rif.average_current[15] ? 16'(~rif.average_current + 16'h1) : rif.average_current;
   assign load_thr = (rif.relax_cfg >> 4) & `GRMC_LOAD_MASK;
   assign dv_thr   = 16'((32'(rif.relax_cfg[`GRMC_DV_MSB:`GRMC_DV_LSB]) + 32'h1) * DV_STEP);
   assign quiet    = primed && (grmc_abs_diff(rif.cell_voltage, prev_v) < dv_thr);
   // Fresh load test, so relaxed drops in the same cycle as unloaded
   assign unl_now  = !(load_thr < cur_mag);

   // ==========================================
   // Interval timer, 2^field base ticks
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         base_cnt <= 32'h0;
      end else if (base_cnt == TICK_CYCLES - 1) begin
         base_cnt <= 32'h0;
      end else begin
         base_cnt <= base_cnt + 32'h1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ivl_cnt  <= 16'h0;
         ivl_tick <= 1'b0;
      end else begin
         ivl_tick <= 1'b0;
         if (base_cnt == TICK_CYCLES - 1) begin
            if (ivl_cnt >= (16'h1 << rif.relax_cfg[`GRMC_DT_MSB:`GRMC_DT_LSB]) - 16'h1) begin
               ivl_cnt  <= 16'h0;
               ivl_tick <= 1'b1;
            end else begin
               ivl_cnt <= ivl_cnt + 16'h1;
            end
         end
      end
   end

   // ==========================================
   // Relaxation search
   always_comb begin
      next_state = state;
      case (state)
         grmc_pkg::GRMC_LOADED:  if (rif.unloaded) next_state = grmc_pkg::GRMC_SEARCH;
         grmc_pkg::GRMC_SEARCH:  if (ivl_tick && quiet) next_state = grmc_pkg::GRMC_QUIET;
         grmc_pkg::GRMC_QUIET:   if (ivl_tick) next_state = quiet ? grmc_pkg::GRMC_RELAXED : grmc_pkg::GRMC_SEARCH;
         grmc_pkg::GRMC_RELAXED: if (ivl_tick && !quiet) next_state = grmc_pkg::GRMC_SEARCH;
         default:                next_state = grmc_pkg::GRMC_LOADED;
      endcase
      if (!rif.unloaded || !unl_now) next_state = grmc_pkg::GRMC_LOADED;
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state           <= grmc_pkg::GRMC_LOADED;
         rif.unloaded    <= 1'b0;
         rif.latch_load  <= 1'b0;
         rif.searching   <= 1'b0;
         rif.relaxed     <= 1'b0;
         rif.relax_event <= 1'b0;
      end else begin
         state           <= next_state;
         rif.unloaded    <= unl_now;
         rif.latch_load  <= unl_now && !rif.unloaded;
         rif.searching   <= next_state == grmc_pkg::GRMC_SEARCH || next_state == grmc_pkg::GRMC_QUIET;
         rif.relaxed     <= next_state == grmc_pkg::GRMC_RELAXED;
         rif.relax_event <= next_state == grmc_pkg::GRMC_RELAXED && state != grmc_pkg::GRMC_RELAXED;
      end
   end

   // First sample after a load only primes the comparison
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prev_v <= 16'h0;
         primed <= 1'b0;
      end else if (state == grmc_pkg::GRMC_LOADED) begin
         primed <= 1'b0;
      end else if (ivl_tick) begin
         prev_v <= rif.cell_voltage;
         primed <= 1'b1;
      end
   end

   // ==========================================
   // Checks
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   AST_RELAX_TWO: assert property (rif.relax_event |-> $past(state == grmc_pkg::GRMC_QUIET) && $past(ivl_tick))
      else $error("Relaxed without two quiet intervals");
   AST_LOADED: assert property ((load_thr < cur_mag) |=> !rif.unloaded && !rif.relaxed)
      else $error("Load above threshold not seen");
   AST_LATCH: assert property (rif.latch_load |-> rif.unloaded && !$past(rif.unloaded))
      else $error("Load latch pulse without unload edge");
   AST_DV_BREAK: assert property (ivl_tick && state == grmc_pkg::GRMC_SEARCH && !quiet |=> state != grmc_pkg::GRMC_QUIET)
      else $error("Voltage step above threshold counted as quiet");
   AST_IVL: assert property (ivl_tick |-> base_cnt == 32'h0 && ivl_cnt == 16'h0)
      else $error("Interval tick off the base tick");
endmodule

// ==== grmc_top.sv ====
// Relaxation and miscellaneous configuration registers of the charge estimator.
// Assumes an Avalon-MM master on clk_in and gauge-core measurements on the same clock.
`timescale 1ns/1ps
`include "grmc_consts.svh"
module grmc_top #(
   parameter int unsigned TICK_CYCLES = `GRMC_TICK_US * 1000 / `GRMC_CLK_NS,
   parameter int unsigned DV_STEP     = `GRMC_DV_STEP_UV * 1000 / `GRMC_VLSB_NV
) (
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic [9:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic             irq_out,
   input  wire logic [15:0] average_current_in,
   input  wire logic [15:0] average_cell_voltage_in,
   input  wire logic        battery_present_in,
   input  wire logic [2:0]  learn_stage_in,
   input  wire logic        final_mix_stage_in,
   input  wire logic [15:0] reported_charge_in,
   input  wire logic [15:0] available_charge_in,
   input  wire logic [15:0] mixed_charge_in,
   input  wire logic [15:0] voltage_charge_in,
   output logic      [15:0] alert_charge_out,
   output logic             unloaded_out,
   output logic             latch_load_out,
   output logic             relax_search_out,
   output logic             relaxed_out,
   output logic             gauge_reset_out,
   output logic             voltage_meas_disable_out,
   output logic      [15:0] host_cell_voltage_out,
   output logic             low_pullup_out,
   output logic      [7:0]  soc_rate_limit_out,
   output logic             servo_mix_active_out,
   output logic      [17:0] servo_mix_nv_out,
   output logic      [2:0]  capacity_learn_flags_out
);
   // ==========================================
   // Helpers
   function automatic logic [15:0] grmc_apply_be(input logic [15:0] old_v, input logic [31:0] wd,
                                                 input logic [3:0] be);
      grmc_apply_be = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
   endfunction

   logic [15:0] relaxation_config;
   logic [15:0] misc_config;
   logic [3:0]  irq_status;
   logic [3:0]  irq_mask;
   logic [2:0]  capacity_learn_flags;
   logic [15:0] host_cell_voltage;
   logic [7:0]  idx;
   logic        wr_acc;
   logic        rd_take;
   logic [15:0] rdata;
   logic        bat_s1;
   logic        bat_s2;
   logic        bat_s3;
   logic        ins_event;
   logic        learn_clr;
   logic [3:0]  irq_event;

   grmc_relax_if rif ();

   assign rif.relax_cfg       = relaxation_config;
   assign rif.average_current = average_current_in;
   // Host-written voltage replaces the measured one while measurement is off
   assign rif.cell_voltage    = misc_config[`GRMC_VEX_BIT] ? host_cell_voltage : average_cell_voltage_in;

   grmc_relax_detect #(
      .TICK_CYCLES (TICK_CYCLES),
      .DV_STEP     (DV_STEP)
   ) u_detect (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .rif      (rif)
   );

   assign unloaded_out     = rif.unloaded;
   assign latch_load_out   = rif.latch_load;
   assign relax_search_out = rif.searching;
   assign relaxed_out      = rif.relaxed;

   // ==========================================
   // Avalon-MM slave, one wait state per access
   assign idx     = avs_address_in[9:2];
   assign wr_acc  = avs_write_in && !avs_waitrequest_out;
   assign rd_take = avs_read_in && avs_waitrequest_out;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         avs_waitrequest_out <= 1'b1;
      end else if (!avs_waitrequest_out) begin
         avs_waitrequest_out <= 1'b1;
      end else if (avs_read_in || avs_write_in) begin
         avs_waitrequest_out <= 1'b0;
      end
   end

   // Unmapped indices read as zero and ignore writes
   always_comb begin
      rdata = 16'h0;
      if (idx == `GRMC_IDX_RELAX) begin
         rdata = relaxation_config;
      end else if (idx == `GRMC_IDX_MISC) begin
         rdata = misc_config;
      end else if (idx == `GRMC_IDX_STATUS) begin
         rdata = {12'h0, irq_status};
      end else if (idx == `GRMC_IDX_MASK) begin
         rdata = {12'h0, irq_mask};
      end else if (idx == `GRMC_IDX_LEARN) begin
         rdata = {13'h0, capacity_learn_flags};
      end else if (idx == `GRMC_IDX_CELLV) begin
         rdata = host_cell_voltage;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         avs_readdata_out <= 32'h0;
      end else if (rd_take) begin
         avs_readdata_out <= {16'h0, rdata};
      end
   end

   // ==========================================
   // Configuration registers
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         relaxation_config <= `GRMC_RELAX_RST;
      end else if (wr_acc && idx == `GRMC_IDX_RELAX) begin
         relaxation_config <= grmc_apply_be(relaxation_config, avs_writedata_in, avs_byteenable_in);
      end
   end

   // The re-initialise bit is a request; a fresh write of one beats the clear
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         misc_config <= `GRMC_MISC_RST;
      end else if (wr_acc && idx == `GRMC_IDX_MISC) begin
         misc_config <= grmc_apply_be(misc_config, avs_writedata_in, avs_byteenable_in);
      end else if (misc_config[`GRMC_REINIT_BIT]) begin
         misc_config[`GRMC_REINIT_BIT] <= 1'b0;
      end
   end

   // Host write wins over the automatic clear so a deliberate set is kept
   assign learn_clr = misc_config[`GRMC_AUTOCLR_BIT] && learn_stage_in == 3'h7 && capacity_learn_flags != 3'h0;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         capacity_learn_flags <= 3'h0;
      end else if (wr_acc && idx == `GRMC_IDX_LEARN && avs_byteenable_in[0]) begin
         capacity_learn_flags <= avs_writedata_in[2:0];
      end else if (learn_clr) begin
         capacity_learn_flags <= 3'h0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         host_cell_voltage <= 16'h0;
      end else if (wr_acc && idx == `GRMC_IDX_CELLV) begin
         host_cell_voltage <= grmc_apply_be(host_cell_voltage, avs_writedata_in, avs_byteenable_in);
      end
   end

   // ==========================================
   // Battery insertion from the thermistor pin monitor
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bat_s1 <= 1'b0;
         bat_s2 <= 1'b0;
         bat_s3 <= 1'b0;
      end else begin
         bat_s1 <= battery_present_in;
         bat_s2 <= bat_s1;
         bat_s3 <= bat_s2;
      end
   end

   assign ins_event = bat_s2 && !bat_s3;

   // ==========================================
   // Interrupt status, write one to clear, events win
   assign irq_event = {misc_config[`GRMC_REINIT_BIT], learn_clr, ins_event, rif.relax_event};

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irq_status <= 4'h0;
      end else if (wr_acc && idx == `GRMC_IDX_STATUS && avs_byteenable_in[0]) begin
         irq_status <= (irq_status & ~avs_writedata_in[3:0]) | irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irq_mask <= 4'h0;
      end else if (wr_acc && idx == `GRMC_IDX_MASK && avs_byteenable_in[0]) begin
         irq_mask <= avs_writedata_in[3:0];
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_status & irq_mask);
      end
   end

   // ==========================================
   // Estimator controls
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         gauge_reset_out <= 1'b0;
      end else begin
         gauge_reset_out <= misc_config[`GRMC_REINIT_BIT]
                            || (ins_event && misc_config[`GRMC_INS_BIT]);
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         soc_rate_limit_out       <= 8'h0;
         servo_mix_active_out     <= 1'b0;
         servo_mix_nv_out         <= 18'h0;
         voltage_meas_disable_out <= 1'b0;
         low_pullup_out           <= 1'b0;
         host_cell_voltage_out    <= 16'h0;
         capacity_learn_flags_out <= 3'h0;
      end else begin
         soc_rate_limit_out       <= 8'((32'(misc_config[`GRMC_RATE_MSB:`GRMC_RATE_LSB]) + 32'h1)
                                        * `GRMC_RATE_STEP);
         servo_mix_active_out     <= final_mix_stage_in
                                     && misc_config[`GRMC_MIX_MSB:`GRMC_MIX_LSB] != 5'h0;
         servo_mix_nv_out         <= 18'(32'(misc_config[`GRMC_MIX_MSB:`GRMC_MIX_LSB]) * `GRMC_MIX_STEP_NV);
         voltage_meas_disable_out <= misc_config[`GRMC_VEX_BIT];
         low_pullup_out           <= misc_config[`GRMC_PULLUP_BIT];
         host_cell_voltage_out    <= host_cell_voltage;
         capacity_learn_flags_out <= capacity_learn_flags;
      end
   end

   // Alert source follows the select a cycle later; no glitch between sources
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         alert_charge_out <= 16'h0;
      end else begin
         case (grmc_pkg::grmc_alert_src_type'(misc_config[`GRMC_ALERT_MSB:`GRMC_ALERT_LSB]))
            grmc_pkg::GRMC_SRC_REPORTED:  alert_charge_out <= reported_charge_in;
            grmc_pkg::GRMC_SRC_AVAILABLE: alert_charge_out <= available_charge_in;
            grmc_pkg::GRMC_SRC_MIXED:     alert_charge_out <= mixed_charge_in;
            default:                      alert_charge_out <= voltage_charge_in;
         endcase
      end
   end

   // ==========================================
   // Checks
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_insert;
      ins_event && misc_config[`GRMC_INS_BIT];
   endsequence

   sequence s_reinit_wr;
      wr_acc && idx == `GRMC_IDX_MISC && avs_byteenable_in[1] && avs_writedata_in[`GRMC_REINIT_BIT];
   endsequence

   sequence s_reinit_run;
      misc_config[`GRMC_REINIT_BIT] ##1 gauge_reset_out;
   endsequence

   AST_RATE: assert property (1'b1 |=> soc_rate_limit_out == 8'(({4'h0, $past(misc_config[15:12])} + 8'h1) << 3))
      else $error("Rate limit not eight per step plus one");
   AST_INSERT: assert property (s_insert |=> gauge_reset_out)
      else $error("Insertion did not reset the estimator");
   AST_NO_INSERT: assert property (ins_event && !misc_config[`GRMC_INS_BIT] && !misc_config[`GRMC_REINIT_BIT]
                                   |=> !gauge_reset_out)
      else $error("Estimator reset with insertion reset disabled");
   AST_REINIT: assert property (s_reinit_wr |=> s_reinit_run)
      else $error("Re-initialise write did not start a reset");
   AST_REINIT_CLR: assert property (misc_config[`GRMC_REINIT_BIT] && !wr_acc |=> !misc_config[`GRMC_REINIT_BIT])
      else $error("Re-initialise request not cleared");
   AST_AUTOCLR: assert property (learn_clr && !(wr_acc && idx == `GRMC_IDX_LEARN)
                                 |=> capacity_learn_flags == 3'h0 && irq_status[2])
      else $error("Learning flags not cleared at stage seven");
   AST_ALERT: assert property (misc_config[1:0] == 2'h2 |=> alert_charge_out == $past(mixed_charge_in))
      else $error("Alert source not the mixed charge");
   AST_SERVO: assert property (!final_mix_stage_in |=> !servo_mix_active_out)
      else $error("Servo mixing before the final stage");
endmodule

// ==== grmc_front_model.sv ====
// Model of the measurement front end that feeds the block.
// Assumes the bench sets the current; charges are fixed and distinct.
`timescale 1ns/1ps
module grmc_front_model (
   input  wire logic [15:0]       current_set_in,
   output logic      [15:0]       current_out,
   output logic      [3:0][15:0]  charge_out
);
   // ==========================================
   // Outputs
   // Distinct charges so a wrong source select cannot match by luck
   assign current_out = current_set_in;
   assign charge_out  = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
endmodule

// ==== gauge_relax_misc_config_test.sv ====
// Self-checking bench of the relaxation and misc configuration block.
// Assumes one 100 MHz clock and the one-wait-cycle Avalon slave.
`timescale 1ns/1ps
module gauge_relax_misc_config_test;
   logic              clk_in = 1'b0;
   logic              rst_b_in = 1'b0;
   logic [9:0]        adr = 10'h000;
   logic [31:0]       wd = 32'h0;
   logic              rd = 1'b0, wr = 1'b0, batt = 1'b0, unl, irq, wait_r, gres;
   logic [31:0]       rdata;
   logic [15:0]       cur_set = 16'h7fff, cur, alert, hcv;
   logic [2:0]        stage = 3'h0, lflg;
   logic [15:0]       curs[4] = '{16'h7fff, 16'h0100, 16'h0101, 16'hff00};
   logic              unl_exp[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   logic [3:0][15:0]  chg;
   logic [7:0]        rate;
   logic [17:0]       mix;
   logic              vdis, pull, fin = 1'b0, sact, srch, rlx, lat;
   logic [15:0]       q[$];
   int                errors = 0, n_compared = 0, n_reset = 0, n_latch = 0;
   // ==========================================
   // Clock, design and partner
   always #5 clk_in = ~clk_in;
   grmc_top #(.TICK_CYCLES(20)) u_grmc_top (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .irq_out(irq),
      .average_current_in(cur), .average_cell_voltage_in(16'h8000), .battery_present_in(batt),
      .learn_stage_in(stage), .final_mix_stage_in(fin), .reported_charge_in(chg[0]),
      .available_charge_in(chg[1]), .mixed_charge_in(chg[2]), .voltage_charge_in(chg[3]),
      .alert_charge_out(alert), .unloaded_out(unl), .latch_load_out(lat), .relax_search_out(srch),
      .relaxed_out(rlx), .gauge_reset_out(gres), .voltage_meas_disable_out(vdis),
      .host_cell_voltage_out(hcv), .low_pullup_out(pull), .soc_rate_limit_out(rate),
      .servo_mix_active_out(sact), .servo_mix_nv_out(mix), .capacity_learn_flags_out(lflg));
   grmc_front_model u_grmc_front_model (.current_set_in(cur_set), .current_out(cur), .charge_out(chg));
   // ==========================================
   // Checking and closing
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d n_compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Read data is judged where it stands, against the oldest note
   always @(posedge clk_in) begin
      if (rd && !wait_r) chk("readdata", rdata, {16'h0000, q.pop_front()});
      if (gres) n_reset++;
      if (lat) n_latch++;
   end
   // Holds the request until waitrequest is seen low, bounded
   task automatic bus(input logic r, input logic [9:0] a, input logic [15:0] d, input logic [15:0] e);
      int i;
      if (r) q.push_back(e);
      adr <= a;
      wd <= {16'h0000, d};
      rd <= r;
      wr <= !r;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_in);
         if (!wait_r) break;
      end
      if (i == 50) begin
         errors++;
         wrap_up();
      end
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_in);
   endtask
   // ==========================================
   // Scenarios
   initial begin
      logic [31:0] v;
      logic [15:0] m;
      v = $urandom(7);
      repeat (5) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      bus(1'b1, 10'h0a8, 16'h0, 16'h1039);
      bus(1'b1, 10'h0ac, 16'h0, 16'h3860);
      chk("rate", rate, 32);
      chk("mix", mix, 18750);
      v = $urandom;
      bus(1'b0, 10'h0a8, v[15:0], 16'h0);
      bus(1'b1, 10'h0a8, 16'h0, v[15:0]);
      bus(1'b1, 10'h3fc, 16'h0, 16'h0000);
      bus(1'b0, 10'h0a8, 16'h1039, 16'h0);
      // Threshold 0x100: equality counts as unloaded, sign ignored
      for (int k = 0; k < 4; k++) begin
         cur_set <= curs[k];
         repeat (3) @(posedge clk_in);
         chk("unloaded", unl, unl_exp[k]);
      end
      cur_set <= 16'h7fff;
      for (int s = 0; s < 4; s++) begin
         v = $urandom;
         m = {v[3:0], 12'h860} | 16'(s) | 16'(s << 2);
         bus(1'b0, 10'h0ac, m, 16'h0);
         repeat (2) @(posedge clk_in);
         chk("alert", alert, chg[s]);
         chk("rate", rate, (v[3:0] + 1) * 8);
         chk("vdis", vdis, s & 1);
         chk("pullup", pull, s >> 1);
      end
      bus(1'b0, 10'h104, 16'h0008, 16'h0);
      bus(1'b0, 10'h0ac, 16'h3c60, 16'h0);
      repeat (3) @(posedge clk_in);
      bus(1'b1, 10'h0ac, 16'h0, 16'h3860);
      bus(1'b1, 10'h100, 16'h0, 16'h0008);
      chk("irq", irq, 1);
      chk("resets", n_reset, 1);
      bus(1'b0, 10'h100, 16'h0008, 16'h0);
      repeat (2) @(posedge clk_in);
      chk("irq", irq, 0);
      batt <= 1'b1;
      repeat (8) @(posedge clk_in);
      chk("resets", n_reset, 2);
      bus(1'b1, 10'h100, 16'h0, 16'h0002);
      chk("irq", irq, 0);
      // Relaxation on host voltage: threshold 0x100, step limit 64 counts, one base tick
      bus(1'b0, 10'h10c, 16'h8000, 16'h0);
      bus(1'b0, 10'h108, 16'h0005, 16'h0);
      bus(1'b0, 10'h0ac, 16'h3864, 16'h0);
      bus(1'b0, 10'h0a8, 16'h1030, 16'h0);
      chk("hostv", hcv, 16'h8000);
      chk("flags", lflg, 3'h5);
      cur_set <= 16'h0080;
      repeat (100) @(posedge clk_in);
      chk("relaxed", rlx, 1);
      chk("latches", n_latch, 3);
      bus(1'b0, 10'h10c, 16'h803f, 16'h0);
      repeat (45) @(posedge clk_in);
      chk("relaxed", rlx, 1);
      bus(1'b0, 10'h10c, 16'h807f, 16'h0);
      repeat (25) @(posedge clk_in);
      chk("relaxed", rlx, 0);
      chk("search", srch, 1);
      bus(1'b0, 10'h0ac, 16'h3874, 16'h0);
      stage <= 3'h7;
      fin <= 1'b1;
      repeat (3) @(posedge clk_in);
      chk("flags", lflg, 0);
      chk("servo", sact, 1);
      bus(1'b0, 10'h0ac, 16'h3014, 16'h0);
      batt <= 1'b0;
      repeat (4) @(posedge clk_in);
      batt <= 1'b1;
      repeat (8) @(posedge clk_in);
      chk("servo", sact, 0);
      chk("mix", mix, 0);
      chk("resets", n_reset, 2);
      bus(1'b0, 10'h0ac, 16'h3860, 16'h0);
      bus(1'b1, 10'h100, 16'h0, 16'h0007);
      wrap_up();
   end
endmodule
